// >>> include/sgl_pkg.sv
// shared constants and types for the segment lcd frame and waveform generator
package sgl_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PIX_REGS = 24;
    localparam int SEGS = 46;
    localparam int COMS = 4;
    localparam int SEGS_LOW = 24;
    localparam int REGS_PER_COM = 3;
    localparam int HIGH_BANK_BASE = 12;
    localparam int BITS_PER_REG = 8;
    localparam logic [ADDR_W-1:0] ADDR_PIX_LAST = 8'h5c;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h60;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h64;
    localparam int WORD_LSB = 2;
    localparam int SYS_DIV_W = 8;
    localparam logic [SYS_DIV_W-1:0] SYS_DIV_LAST = 8'hff;
    localparam int CNT_W = 11;
    localparam logic [CNT_W-1:0] HALF_BASE = 11'h010;
    localparam logic [CNT_W-1:0] K_STATIC = 11'h004;
    localparam logic [CNT_W-1:0] K_HALF = 11'h002;
    localparam logic [CNT_W-1:0] K_MULTI = 11'h001;
    localparam int SYNC_SRCS = 2;

    typedef enum logic [1:0] {
        MUX_STATIC = 2'b00,
        MUX_HALF = 2'b01,
        MUX_THIRD = 2'b10,
        MUX_QUARTER = 2'b11
    } sgl_mux_e;

    typedef enum logic [1:0] {
        SRC_SYS_DIV = 2'b00,
        SRC_SEC_OSC = 2'b01,
        SRC_LF_INT = 2'b10,
        SRC_NONE = 2'b11
    } sgl_src_e;

    typedef enum logic [1:0] {
        LVL_OFF = 2'b00,
        LVL_LOW = 2'b01,
        LVL_MID = 2'b10,
        LVL_HIGH = 2'b11
    } sgl_lvl_e;

    typedef enum logic [1:0] {
        RUN_IDLE = 2'b00,
        RUN_ACTIVE = 2'b01,
        RUN_STOPPING = 2'b10
    } sgl_run_e;

    typedef struct packed {
        logic [3:0] prescale;
        logic sleep_dis;
        sgl_src_e src;
        logic waveform_type_bit;
        sgl_mux_e mux;
        logic en;
    } sgl_ctrl_s;

    localparam int CTRL_W = 11;
    localparam sgl_ctrl_s CTRL_RESET = '{4'h0, 1'b0, SRC_SYS_DIV, 1'b0, MUX_STATIC, 1'b0};

    typedef struct packed {
        logic halted;
        logic frame_odd;
        logic [1:0] com_idx;
        logic half;
        logic active;
    } sgl_stat_s;

    localparam int STAT_W = 6;
endpackage

// >>> rtl/sgl_frame_wave.sv
// segment lcd frame timing, pixel mapping and drive waveform generator
`timescale 1ns/1ps
`default_nettype none
module sgl_frame_wave (
    input wire logic CLK, // 20 mhz system clock
    input wire logic RESETN, // synchronous reset, active low
    input wire logic [sgl_pkg::ADDR_W-1:0] AVS_ADDRESS, // byte address
    input wire logic AVS_READ, // read request
    input wire logic AVS_WRITE, // write request
    input wire logic [sgl_pkg::DATA_W-1:0] AVS_WRITEDATA, // write data
    input wire logic [3:0] AVS_BYTEENABLE, // byte lanes
    output logic [sgl_pkg::DATA_W-1:0] AVS_READDATA, // read data
    output logic AVS_WAITREQUEST, // stall
    input wire logic SEC_OSC_IN, // secondary crystal oscillator pin
    input wire logic LF_OSC_IN, // low-frequency internal oscillator
    input wire logic SLEEP_REQ, // core executes sleep, level
    output logic [sgl_pkg::COMS-1:0][1:0] COM_LVL, // common drive level codes
    output logic [sgl_pkg::SEGS-1:0][1:0] SEG_LVL, // segment drive level codes
    output logic IRQ_SHUTDOWN, // pulse, controller became inactive
    output logic IRQ_FRAME // pulse, frame timing mark
);
    import sgl_pkg::*;

    // half of a common slice in source ticks: k x prescale x 16
    function automatic logic [CNT_W-1:0] half_len(input sgl_mux_e m, input logic [3:0] ps);
        logic [CNT_W-1:0] k;
        logic [CNT_W-1:0] p;
        k = K_MULTI;
        p = (ps == 4'h0) ? 11'h001 : {7'h00, ps};
        case (m)
            MUX_STATIC: k = K_STATIC;
            MUX_HALF: k = K_HALF;
            default: k = K_MULTI;
        endcase
        half_len = CNT_W'(k * p * HALF_BASE);
    endfunction

    function automatic logic pix_bit(input logic [PIX_REGS-1:0][7:0] bank,
                                     input logic [1:0] com, input int seg);
        int r;
        int b;
        r = 0;
        b = 0;
        if (seg < SEGS_LOW) begin
            r = int'(com) * REGS_PER_COM + seg / BITS_PER_REG;
            b = seg % BITS_PER_REG;
        end else begin
            r = HIGH_BANK_BASE + int'(com) * REGS_PER_COM + (seg - SEGS_LOW) / BITS_PER_REG;
            b = (seg - SEGS_LOW) % BITS_PER_REG;
        end
        pix_bit = bank[r][b];
    endfunction

    logic [PIX_REGS-1:0][7:0] pix_reg;
    sgl_ctrl_s ctrl_reg;
    logic wait_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [SYS_DIV_W-1:0] sysdiv_reg;
    logic sys_tick;
    logic [SYNC_SRCS-1:0] s1_reg;
    logic [SYNC_SRCS-1:0] s2_reg;
    logic [SYNC_SRCS-1:0] s3_reg;
    logic [SYNC_SRCS-1:0] lvl_reg;
    logic [SYNC_SRCS-1:0] rise;
    logic src_tick;
    sgl_run_e run_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic half_reg;
    logic [1:0] com_reg;
    logic odd_reg;
    logic halted;
    logic half_end;
    logic frame_end;
    logic phase;
    logic [COMS-1:0][1:0] com_next;
    logic [SEGS-1:0][1:0] seg_next;
    logic bus_req;
    logic bus_ack;
    logic [ADDR_W-1:0] addr_word;
    sgl_stat_s stat;

    assign bus_req = AVS_READ | AVS_WRITE;
    assign bus_ack = bus_req & ~wait_reg;
    assign addr_word = {AVS_ADDRESS[ADDR_W-1:WORD_LSB], 2'b00};

    // every access answers after one wait cycle, so decode sees stable inputs
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            wait_reg <= 1'b1;
        end else if (bus_req && wait_reg) begin
            wait_reg <= 1'b0;
        end else begin
            wait_reg <= 1'b1;
        end
    end

    assign AVS_WAITREQUEST = wait_reg;

    assign stat = '{halted, odd_reg, com_reg, half_reg, run_reg != RUN_IDLE};

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            rdata_reg <= '0;
        end else if (AVS_READ && wait_reg) begin
            if (addr_word <= ADDR_PIX_LAST) begin
                rdata_reg <= {24'h000000, pix_reg[AVS_ADDRESS[6:WORD_LSB]]};
            end else if (addr_word == ADDR_CTRL) begin
                rdata_reg <= {21'h000000, ctrl_reg};
            end else if (addr_word == ADDR_STAT) begin
                rdata_reg <= {26'h0000000, stat};
            end else begin
                rdata_reg <= '0;
            end
        end
    end

    assign AVS_READDATA = rdata_reg;

    // pixel bank; writes land only in low byte lane
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            pix_reg <= '0;
        end else if (AVS_WRITE && bus_ack && AVS_BYTEENABLE[0] && addr_word <= ADDR_PIX_LAST) begin
            pix_reg[AVS_ADDRESS[6:WORD_LSB]] <= AVS_WRITEDATA[7:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            ctrl_reg <= CTRL_RESET;
        end else if (AVS_WRITE && bus_ack && addr_word == ADDR_CTRL) begin
            if (AVS_BYTEENABLE[0]) begin
                ctrl_reg[7:0] <= AVS_WRITEDATA[7:0];
            end
            if (AVS_BYTEENABLE[1]) begin
                ctrl_reg[CTRL_W-1:8] <= AVS_WRITEDATA[CTRL_W-1:8];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            sysdiv_reg <= '0;
        end else begin
            sysdiv_reg <= sysdiv_reg + 8'h01;
        end
    end

    assign sys_tick = (sysdiv_reg == SYS_DIV_LAST);

    // oscillator pins are asynchronous; a change counts once stages two and three agree
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            lvl_reg <= '0;
        end else begin
            s1_reg <= {LF_OSC_IN, SEC_OSC_IN};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < SYNC_SRCS; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    lvl_reg[i] <= s3_reg[i];
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < SYNC_SRCS; i++) begin
            rise[i] = (s2_reg[i] == s3_reg[i]) && s3_reg[i] && !lvl_reg[i];
        end
    end

    always_comb begin
        case (ctrl_reg.src)
            SRC_SYS_DIV: src_tick = sys_tick;
            SRC_SEC_OSC: src_tick = rise[0];
            SRC_LF_INT: src_tick = rise[1];
            default: src_tick = 1'b0;
        endcase
    end

    // divided system clock stops on sleep whatever the sleep bit
    assign halted = SLEEP_REQ && (ctrl_reg.sleep_dis || ctrl_reg.src == SRC_SYS_DIV);

    // slice = two halves of k x prescale x 16
    assign half_end = src_tick && !halted && run_reg != RUN_IDLE
                      && cnt_reg >= half_len(ctrl_reg.mux, ctrl_reg.prescale) - 11'h001;
    assign frame_end = half_end && half_reg && com_reg >= ctrl_reg.mux;

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            run_reg <= RUN_IDLE;
        end else begin
            case (run_reg)
                RUN_IDLE: begin
                    if (ctrl_reg.en) begin
                        run_reg <= RUN_ACTIVE;
                    end
                end
                RUN_ACTIVE: begin
                    if (!ctrl_reg.en) begin
                        run_reg <= RUN_STOPPING;
                    end
                end
                RUN_STOPPING: begin
                    // disabling completes only at end of frame, which keeps dc balance only when phase is per half slice
                    if (ctrl_reg.en) begin
                        run_reg <= RUN_ACTIVE;
                    end else if (frame_end) begin
                        run_reg <= RUN_IDLE;
                    end
                end
                default: run_reg <= RUN_IDLE;
            endcase
        end
    end

    // frame begins at common zero, first half
    always_ff @(posedge CLK) begin
        if (!RESETN || run_reg == RUN_IDLE) begin
            cnt_reg <= '0;
            half_reg <= 1'b0;
            com_reg <= 2'b00;
            odd_reg <= 1'b0;
        end else if (half_end) begin
            cnt_reg <= '0;
            half_reg <= ~half_reg;
            if (half_reg) begin
                com_reg <= frame_end ? 2'b00 : com_reg + 2'b01;
            end
            if (frame_end) begin
                odd_reg <= ~odd_reg;
            end
        end else if (src_tick && !halted) begin
            cnt_reg <= cnt_reg + 11'h001;
        end
    end

    // phase per half slice or per frame
    assign phase = ctrl_reg.waveform_type_bit ? odd_reg : half_reg;

    // selected common swings full, other used commons sit mid, unused ones off
    always_comb begin
        for (int c = 0; c < COMS; c++) begin
            if (run_reg == RUN_IDLE || halted || c > int'(ctrl_reg.mux)) begin
                com_next[c] = LVL_OFF;
            end else if (c == int'(com_reg)) begin
                com_next[c] = phase ? LVL_HIGH : LVL_LOW;
            end else begin
                com_next[c] = LVL_MID;
            end
        end
    end

    // dark drives opposite the common, clear follows it
    always_comb begin
        for (int n = 0; n < SEGS; n++) begin
            if (run_reg == RUN_IDLE || halted) begin
                seg_next[n] = LVL_OFF;
            end else if (phase ^ pix_bit(pix_reg, com_reg, n)) begin
                seg_next[n] = LVL_HIGH;
            end else begin
                seg_next[n] = LVL_LOW;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            COM_LVL <= '0;
            SEG_LVL <= '0;
        end else begin
            COM_LVL <= com_next;
            SEG_LVL <= seg_next;
        end
    end

    // shutdown completes at the frame end
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            IRQ_SHUTDOWN <= 1'b0;
        end else begin
            IRQ_SHUTDOWN <= (run_reg == RUN_STOPPING) && !ctrl_reg.en && frame_end;
        end
    end

    // only alternating, non-static; marks end of a complete phase pair
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            IRQ_FRAME <= 1'b0;
        end else begin
            IRQ_FRAME <= frame_end && odd_reg && ctrl_reg.waveform_type_bit && ctrl_reg.mux != MUX_STATIC;
        end
    end
endmodule
`default_nettype wire

// >>> dv/sgl_properties.sv
// assertions on the frame generator's ports
`timescale 1ns/1ps
`default_nettype none
module sgl_chk (
    input wire logic CLK, // clock
    input wire logic RESETN, // reset
    input wire logic [sgl_pkg::ADDR_W-1:0] AVS_ADDRESS, // address
    input wire logic AVS_WRITE, // write
    input wire logic [sgl_pkg::DATA_W-1:0] AVS_WRITEDATA, // data
    input wire logic AVS_WAITREQUEST, // stall
    input wire logic SLEEP_REQ, // sleep
    input wire logic [sgl_pkg::COMS-1:0][1:0] COM_LVL, // commons
    input wire logic [sgl_pkg::SEGS-1:0][1:0] SEG_LVL, // segments
    input wire logic IRQ_SHUTDOWN, // shutdown
    input wire logic IRQ_FRAME // frame
);
    import sgl_pkg::*;
    sgl_ctrl_s ctrl_reg;
    sgl_mux_e mux_d;
    logic [COMS-1:0] sel;
    logic [COMS-1:0] unused;
    logic seg_mid;
    // shadow of control, taken at the accepting edge
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            ctrl_reg <= CTRL_RESET;
        end else if (AVS_WRITE && !AVS_WAITREQUEST &&
                     AVS_ADDRESS[ADDR_W-1:WORD_LSB] == ADDR_CTRL[ADDR_W-1:WORD_LSB]) begin
            ctrl_reg <= sgl_ctrl_s'(AVS_WRITEDATA[CTRL_W-1:0]);
        end
    end
    // registered drive lags the control by one cycle
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            mux_d <= MUX_STATIC;
        end else begin
            mux_d <= ctrl_reg.mux;
        end
    end
    always_comb begin
        seg_mid = 1'b0;
        for (int c = 0; c < COMS; c++) begin
            sel[c] = COM_LVL[c][0];
            unused[c] = c > int'(mux_d) && COM_LVL[c] != LVL_OFF;
        end
        for (int n = 0; n < SEGS; n++) begin
            seg_mid = seg_mid | (SEG_LVL[n] == LVL_MID);
        end
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);
    sequence s_slice_on;
        sel[0] ##1 sel[0];
    endsequence
    property p_one_common;
        $onehot0(sel);
    endproperty
    a_one_common: assert property (p_one_common) else $error("two commons selected");
    property p_unused_off;
        unused == '0;
    endproperty
    a_unused_off: assert property (p_unused_off) else $error("unused common driven");
    property p_seg_levels;
        !seg_mid;
    endproperty
    a_seg_levels: assert property (p_seg_levels) else $error("segment at mid level");
    property p_sleep_halt;
        (SLEEP_REQ && ctrl_reg.src == SRC_SYS_DIV) [*2] |-> COM_LVL == '0 && SEG_LVL == '0;
    endproperty
    a_sleep_halt: assert property (p_sleep_halt) else $error("drive not halted");
    property p_shut_cause;
        IRQ_SHUTDOWN |-> !$past(ctrl_reg.en);
    endproperty
    a_shut_cause: assert property (p_shut_cause) else $error("shutdown while enabled");
    property p_frame_cause;
        IRQ_FRAME |-> $past(ctrl_reg.waveform_type_bit) && $past(ctrl_reg.mux) != MUX_STATIC;
    endproperty
    a_frame_cause: assert property (p_frame_cause) else $error("frame pulse not allowed");
    property p_frame_common_line_zero;
        IRQ_FRAME |-> ##[0:1] sel[0];
    endproperty
    a_frame_common_line_zero: assert property (p_frame_common_line_zero) else $error("frame not at common 0");
    property p_type_a;
        $past(sel[0]) && !sel[0] && !ctrl_reg.waveform_type_bit && !SLEEP_REQ && !$past(SLEEP_REQ)
            |-> $past(COM_LVL[0]) == LVL_HIGH;
    endproperty
    a_type_a: assert property (p_type_a) else $error("slice ended without reversal");
    property p_type_b;
        ctrl_reg.waveform_type_bit && ctrl_reg.mux != MUX_STATIC ##0 s_slice_on |-> $stable(COM_LVL[0]);
    endproperty
    a_type_b: assert property (p_type_b) else $error("phase changed inside slice");
endmodule
bind sgl_frame_wave sgl_chk u_sgl_chk (.CLK(CLK), .RESETN(RESETN), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .SLEEP_REQ(SLEEP_REQ), .COM_LVL(COM_LVL), .SEG_LVL(SEG_LVL), .IRQ_SHUTDOWN(IRQ_SHUTDOWN),
    .IRQ_FRAME(IRQ_FRAME));
`default_nettype wire

// >>> dv/sgl_glass.sv
// passive glass: integrates each pixel voltage and its square
`timescale 1ns/1ps
`default_nettype none
module sgl_glass (
    input wire logic CLK, // clock
    input wire logic [sgl_pkg::COMS-1:0][1:0] com_lvl, // commons
    input wire logic [sgl_pkg::SEGS-1:0][1:0] seg_lvl, // segments
    input wire logic clr, // zero sums
    input wire logic run // integrate
);
    import sgl_pkg::*;
    int dc[COMS][SEGS];
    int sq[COMS][SEGS];
    always @(posedge CLK) begin
        for (int c = 0; c < COMS; c++) begin
            for (int n = 0; n < SEGS; n++) begin
                int v;
                v = int'(com_lvl[c]) - int'(seg_lvl[n]);
                dc[c][n] = clr ? 0 : dc[c][n] + (run ? v : 0);
                sq[c][n] = clr ? 0 : sq[c][n] + (run ? v * v : 0);
            end
        end
    end
endmodule
`default_nettype wire

// >>> dv/segment_lcd_frame_waveform_bench.sv
// bench: registers, frame rates, drive levels, interrupts, sleep
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s exp %0h got %0h", nm, (e), (g)); end end
module segment_lcd_frame_waveform_bench;
    import sgl_pkg::*;
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    logic [ADDR_W-1:0] AVS_ADDRESS = '0;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [DATA_W-1:0] AVS_WRITEDATA = '0;
    logic [DATA_W-1:0] AVS_READDATA;
    logic AVS_WAITREQUEST;
    logic SEC_OSC_IN = 1'b0;
    logic LF_OSC_IN = 1'b0;
    logic SLEEP_REQ = 1'b0;
    logic [COMS-1:0][1:0] COM_LVL;
    logic [SEGS-1:0][1:0] SEG_LVL;
    logic IRQ_SHUTDOWN;
    logic IRQ_FRAME;
    logic clr = 1'b0;
    logic run = 1'b0;
    int osc_div = 0;
    int fail_count = 0;
    int check_count = 0;
    sgl_frame_wave u_sgl_frame_wave (.CLK(CLK), .RESETN(RESETN), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_BYTEENABLE(4'hf), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .SEC_OSC_IN(SEC_OSC_IN), .LF_OSC_IN(LF_OSC_IN), .SLEEP_REQ(SLEEP_REQ),
        .COM_LVL(COM_LVL), .SEG_LVL(SEG_LVL), .IRQ_SHUTDOWN(IRQ_SHUTDOWN), .IRQ_FRAME(IRQ_FRAME));
    sgl_glass u_sgl_glass (.CLK(CLK), .com_lvl(COM_LVL), .seg_lvl(SEG_LVL), .clr(clr), .run(run));
    always #25 CLK = !CLK;
    // oscillators: one tick per 8 and per 6 clocks
    always @(posedge CLK) begin
        osc_div <= osc_div + 1;
        SEC_OSC_IN <= (osc_div % 4 == 3) ? !SEC_OSC_IN : SEC_OSC_IN;
        LF_OSC_IN <= (osc_div % 3 == 2) ? !LF_OSC_IN : LF_OSC_IN;
    end
    function automatic logic [7:0] pat(input int i);
        return 8'(i * 8'h25 + 8'h5a);
    endfunction
    // bank and bit of a pixel
    function automatic logic dark(input int c, input int n);
        logic [7:0] b;
        b = n < 24 ? pat(c * 3 + n / 8) : pat(12 + c * 3 + (n - 24) / 8);
        return b[n % 8];
    endfunction
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
        output logic [DATA_W-1:0] q);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        // no cycle count assumed; only the watchdog ends a hung access
        do begin
            @(posedge CLK);
        end while (AVS_WAITREQUEST !== 1'b0);
        q = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic wait_irq(input logic shut, input int lim, output int n);
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while ((shut ? IRQ_SHUTDOWN : IRQ_FRAME) !== 1'b1 && n < lim);
    endtask
    task automatic judge(input int mx);
        int rd;
        int rc;
        rd = -1;
        rc = -1;
        for (int c = 0; c <= mx; c++) begin
            for (int n = 0; n < SEGS; n++) begin
                `CHK("net dc", 0, u_sgl_glass.dc[c][n])
                rd = (dark(c, n) && rd < 0) ? u_sgl_glass.sq[c][n] : rd;
                rc = (!dark(c, n) && rc < 0) ? u_sgl_glass.sq[c][n] : rc;
                `CHK("rms", dark(c, n) ? rd : rc, u_sgl_glass.sq[c][n])
            end
        end
        `CHK("dark above clear", 1'b1, rd > rc)
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        logic [DATA_W-1:0] q;
        int fr;
        int win;
        int n;
        sgl_ctrl_s ctl;
        repeat (3) @(posedge CLK);
        RESETN <= 1'b1;
        @(posedge CLK);
        bus(0, ADDR_STAT, '0, q);
        `CHK("idle status", 32'h0, q)
        for (int i = 0; i < PIX_REGS; i++)
            bus(1, ADDR_W'(4 * i), {24'h0, pat(i)}, q);
        for (int i = 0; i < PIX_REGS; i++) begin
            bus(0, ADDR_W'(4 * i), '0, q);
            `CHK("pixel reg", {24'h0, pat(i)}, q)
        end
        bus(1, 8'h68, 32'hffffffff, q);
        bus(0, 8'h68, '0, q);
        `CHK("unmapped", 32'h0, q)
        for (int w = 0; w < 2; w++) begin
            for (int m = 0; m < 4; m++) begin
                fr = (w ? 8 : 6) * (m % 2 + 1) * 32 * (m < 2 ? 4 : m + 1);
                win = w ? 2 * fr : fr;
                // both oscillators, sleeping while kept running
                ctl = '{4'(m % 2 + 1), 1'b0, w ? SRC_SEC_OSC : SRC_LF_INT, w[0],
                        sgl_mux_e'(m), 1'b1};
                SLEEP_REQ <= (m == 3);
                clr <= 1'b1;
                bus(1, ADDR_CTRL, {21'h0, ctl}, q);
                bus(0, ADDR_CTRL, '0, q);
                `CHK("ctrl", {21'h0, ctl}, q)
                clr <= 1'b0;
                `CHK("first common", LVL_LOW, COM_LVL[0])
                if (w && m) begin
                    wait_irq(0, win + 100, n);
                    run <= 1'b1;
                    wait_irq(0, win + 100, n);
                    `CHK("frame pair", win, n)
                end else begin
                    repeat (win) @(posedge CLK);
                    run <= 1'b1;
                    wait_irq(0, win, n);
                    `CHK("no frame irq", win, n)
                end
                run <= 1'b0;
                @(posedge CLK);
                judge(m);
                if (m == 3) begin
                    bus(0, ADDR_STAT, '0, q);
                    `CHK("kept running", 1'b0, q[5])
                end
                SLEEP_REQ <= 1'b0;
                ctl.en = 1'b0;
                bus(1, ADDR_CTRL, {21'h0, ctl}, q);
                wait_irq(1, 2 * win + 100, n);
                `CHK("shutdown irq", 1'b1, IRQ_SHUTDOWN)
                bus(0, ADDR_STAT, '0, q);
                `CHK("inactive", 1'b0, q[0])
            end
        end
        ctl = '{4'h1, 1'b0, SRC_SYS_DIV, 1'b0, MUX_QUARTER, 1'b0};
        bus(1, ADDR_CTRL, {21'h0, ctl}, q);
        // sleep only once shut down, no dc on glass
        SLEEP_REQ <= 1'b1;
        repeat (3) @(posedge CLK);
        `CHK("halted commons", 8'h0, COM_LVL)
        `CHK("halted segments", 92'h0, SEG_LVL)
        bus(0, ADDR_STAT, '0, q);
        `CHK("halted flag", 1'b1, q[5])
        tally_and_finish();
    end
    initial begin
        repeat (60000) @(posedge CLK);
        fail_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
